/* File: independent_watchdog_config.v */
// independent watchdog: mode select, settings, divider, window, countdown
// assumes ref_clk_i is the dedicated watchdog clock; low-power entry is
// asynchronous, all other inputs come from logic on the same clock
//
// Behaviour
// RULE_01: auto-start takes all settings from option word
// RULE_02: register mode takes settings at refresh; here reset/irq select and count-stop bit are read live instead
// RULE_03: window start select sets permitted-period start
// RULE_04: window end select sets permitted-period end
// RULE_05: one bit picks reset or interrupt on error
// RULE_06: count-stop bit halts counting in low power
// RULE_07: first variant table 1024 to 16384 cycles
// RULE_08: second variant table 128 to 2048 cycles
// RULE_09: fourteen-bit down-counter on divided clock
// RULE_10: software refreshes with 00h then FFh
// RULE_11: divider ratios 1,16,32,64,128,256
// RULE_12: parameter picks which timeout table decodes
`timescale 1ns/1ps
`include "independent_watchdog_regs.vh"

module independent_watchdog_config #(
  parameter SECOND_VARIANT = 0
) (
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire        auto_start_mode_i,
  input  wire [3:0]  autostart_divider_select_i,
  input  wire [1:0]  autostart_timeout_select_i,
  input  wire [1:0]  autostart_window_start_select_i,
  input  wire [1:0]  autostart_window_end_select_i,
  input  wire        autostart_reset_or_irq_select_i,
  input  wire        autostart_lowpower_count_stop_i,
  input  wire [3:0]  divider_select_i,
  input  wire [1:0]  timeout_select_i,
  input  wire [1:0]  window_start_select_i,
  input  wire [1:0]  window_end_select_i,
  input  wire        reset_or_irq_select_i,
  input  wire        lowpower_count_stop_i,
  input  wire        refresh_write_i,
  input  wire [7:0]  refresh_data_i,
  input  wire        lowpower_state_i,
  output reg         reset_request_o,
  output reg         irq_request_o,
  output reg         underflow_event_o,
  output reg         refresh_error_event_o,
  output reg         counting_o,
  output reg         refresh_window_o,
  output reg  [13:0] count_value_o
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function [7:0] div_limit;
    input [3:0] sel;
    begin
      case (sel)
        `DIV_SEL_1:   div_limit = `DIV_LIM_1;
        `DIV_SEL_16:  div_limit = `DIV_LIM_16;
        `DIV_SEL_32:  div_limit = `DIV_LIM_32;
        `DIV_SEL_64:  div_limit = `DIV_LIM_64;
        `DIV_SEL_128: div_limit = `DIV_LIM_128;
        `DIV_SEL_256: div_limit = `DIV_LIM_256;
        default:      div_limit = `DIV_LIM_1;
      endcase
    end
  endfunction

  function [13:0] start_value;
    input [1:0] sel;
    begin
      if (SECOND_VARIANT != 0) begin // [RULE_12]
        case (sel) // [RULE_08]
          2'h0:    start_value = `V2_START_00;
          2'h1:    start_value = `V2_START_01;
          2'h2:    start_value = `V2_START_10;
          default: start_value = `V2_START_11;
        endcase
      end else begin
        case (sel) // [RULE_07]
          2'h0:    start_value = `V1_START_00;
          2'h1:    start_value = `V1_START_01;
          2'h2:    start_value = `V1_START_10;
          default: start_value = `V1_START_11;
        endcase
      end
    end
  endfunction

  // quarter multiples of the period, 15 bits wide
  function [14:0] quarters;
    input [1:0]  n;
    input [13:0] sv;
    reg   [14:0] q;
    begin
      q = ({1'b0, sv} + 15'h0001) >> 2;
      case (n)
        2'h0:    quarters = 15'h0000;
        2'h1:    quarters = q;
        2'h2:    quarters = q << 1;
        default: quarters = (q << 1) + q;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam SEQ_IDLE  = 2'b01;
  localparam SEQ_ARMED = 2'b10;

  reg [1:0]  seq_state;
  reg        lp_meta;
  reg        lp_sync;
  reg        booted;
  reg        mode_auto;
  reg [3:0]  cur_div;
  reg [1:0]  cur_timeout_select;
  reg [1:0]  cur_window_start_select;
  reg [1:0]  cur_window_end_select;
  reg        auto_rst_irq;
  reg        auto_cstp;
  reg [7:0]  prescale;
  reg [13:0] count;
  reg        counting;

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  wire        sel_irq   = mode_auto ? auto_rst_irq
                                    : reset_or_irq_select_i;
  wire        sel_cstp  = mode_auto ? auto_cstp : lowpower_count_stop_i;
  wire        stopped   = sel_cstp & lp_sync; // [RULE_06]
  wire        tick      = counting & ~stopped &
                          (prescale == div_limit(cur_div)); // [RULE_11]
  wire [13:0] cur_start = start_value(cur_timeout_select);
  // start = 0..75 % of period elapsed, end = 75..0 % remaining
  wire [14:0] start_lim = quarters(2'h3 - cur_window_start_select, cur_start)
                          + quarters(2'h1, cur_start); // [RULE_03]
  wire [14:0] end_lim   = quarters(2'h3 - cur_window_end_select, cur_start); // [RULE_04]
  wire        in_window = ({1'b0, count} < start_lim) &
                          ({1'b0, count} >= end_lim);
  wire        refresh   = refresh_write_i &
                          (refresh_data_i == `REFRESH_SECOND) &
                          (seq_state == SEQ_ARMED); // [RULE_10]
  wire        ref_err   = refresh & counting & ~in_window;
  wire        underflow = tick & (count == 14'h0000);
  wire        error     = ref_err | underflow;

  // ----------------------------------------------------------------
  // low-power entry synchroniser
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lp_meta <= 1'b0;
      lp_sync <= 1'b0;
    end else begin
      lp_meta <= lowpower_state_i;
      lp_sync <= lp_meta;
    end
  end

  // ----------------------------------------------------------------
  // refresh byte sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_state <= SEQ_IDLE;
    end else if (refresh_write_i) begin
      case (seq_state)
        SEQ_IDLE:  seq_state <= (refresh_data_i == `REFRESH_FIRST) ?
                                SEQ_ARMED : SEQ_IDLE;
        SEQ_ARMED: seq_state <= (refresh_data_i == `REFRESH_FIRST) ?
                                SEQ_ARMED : SEQ_IDLE;
        default:   seq_state <= SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // settings, divider and countdown
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      booted       <= 1'b0;
      mode_auto    <= 1'b0;
      cur_div      <= `RST_SEL4;
      cur_timeout_select     <= `RST_SEL2;
      cur_window_start_select     <= `RST_SEL2;
      cur_window_end_select     <= `RST_SEL2;
      auto_rst_irq <= 1'b0;
      auto_cstp    <= 1'b0;
      prescale     <= `RST_PRESCALE;
      count        <= `RST_COUNT;
      counting     <= 1'b0;
    end else if (!booted) begin
      booted    <= 1'b1;
      mode_auto <= auto_start_mode_i;
      if (auto_start_mode_i) begin // [RULE_01]
        cur_div      <= autostart_divider_select_i;
        cur_timeout_select     <= autostart_timeout_select_i;
        cur_window_start_select     <= autostart_window_start_select_i;
        cur_window_end_select     <= autostart_window_end_select_i;
        auto_rst_irq <= autostart_reset_or_irq_select_i;
        auto_cstp    <= autostart_lowpower_count_stop_i;
        count        <= start_value(autostart_timeout_select_i);
        counting     <= 1'b1;
      end
    end else if (error) begin
      prescale <= `RST_PRESCALE;
      count    <= cur_start;
      counting <= mode_auto;
    end else if (refresh) begin
      prescale <= `RST_PRESCALE;
      counting <= 1'b1;
      if (mode_auto) begin
        count <= cur_start;
      end else begin // [RULE_02]
        cur_div  <= divider_select_i;
        cur_timeout_select <= timeout_select_i;
        cur_window_start_select <= window_start_select_i;
        cur_window_end_select <= window_end_select_i;
        count    <= start_value(timeout_select_i);
      end
    end else if (counting && !stopped) begin
      if (tick) begin
        prescale <= `RST_PRESCALE;
        count    <= count - 14'h0001; // [RULE_09]
      end else begin
        prescale <= prescale + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_request_o       <= 1'b0;
      irq_request_o         <= 1'b0;
      underflow_event_o     <= 1'b0;
      refresh_error_event_o <= 1'b0;
      counting_o            <= 1'b0;
      refresh_window_o      <= 1'b0;
      count_value_o         <= `RST_COUNT;
    end else begin
      reset_request_o       <= booted & error & ~sel_irq; // [RULE_05]
      irq_request_o         <= booted & error & sel_irq; // [RULE_05]
      underflow_event_o     <= booted & underflow;
      refresh_error_event_o <= booted & ref_err;
      counting_o            <= counting;
      refresh_window_o      <= counting & in_window;
      count_value_o         <= count;
    end
  end

endmodule // independent_watchdog_config

/* File: independent_watchdog_regs.vh */
// constants of the independent watchdog configuration block
// assumes inclusion by the watchdog module only
`ifndef INDEPENDENT_WATCHDOG_REGS_VH
`define INDEPENDENT_WATCHDOG_REGS_VH

// divider select codes
`define DIV_SEL_1        4'h0
`define DIV_SEL_16       4'h2
`define DIV_SEL_32       4'h3
`define DIV_SEL_64       4'h4
`define DIV_SEL_128      4'hF
`define DIV_SEL_256      4'h5

// divider terminal counts (ratio minus one)
`define DIV_LIM_1        8'h00
`define DIV_LIM_16       8'h0F
`define DIV_LIM_32       8'h1F
`define DIV_LIM_64       8'h3F
`define DIV_LIM_128      8'h7F
`define DIV_LIM_256      8'hFF

// counter start values, first variant
`define V1_START_00      14'h03FF
`define V1_START_01      14'h0FFF
`define V1_START_10      14'h1FFF
`define V1_START_11      14'h3FFF

// counter start values, second variant
`define V2_START_00      14'h007F
`define V2_START_01      14'h01FF
`define V2_START_10      14'h03FF
`define V2_START_11      14'h07FF

// refresh sequence bytes
`define REFRESH_FIRST    8'h00
`define REFRESH_SECOND   8'hFF

// reset values
`define RST_COUNT        14'h0000
`define RST_PRESCALE     8'h00
`define RST_SEL4         4'h0
`define RST_SEL2         2'h0

`endif

/* File: wdt_config_properties.sv */
// concurrent checks on the watchdog configuration block outputs
// assumes bind onto independent_watchdog_config, one clock domain
`timescale 1ns/1ps
module wdt_config_properties (
  input wire        ref_clk_i,
  input wire        reset_n_i,
  input wire        auto_start_mode_i,
  input wire        autostart_lowpower_count_stop_i,
  input wire        lowpower_count_stop_i,
  input wire        lowpower_state_i,
  input wire        reset_request_o,
  input wire        irq_request_o,
  input wire        underflow_event_o,
  input wire        refresh_error_event_o,
  input wire        counting_o,
  input wire        refresh_window_o,
  input wire [13:0] count_value_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire stop_sel = auto_start_mode_i ? autostart_lowpower_count_stop_i
                                    : lowpower_count_stop_i;
  one_request_a:
    assert property (!(reset_request_o && irq_request_o))
    else $error("reset and irq requests together");
  request_cause_a:
    assert property ((reset_request_o || irq_request_o) |->
      (underflow_event_o || refresh_error_event_o))
    else $error("request without error event");
  event_request_a:
    assert property ((underflow_event_o || refresh_error_event_o) |->
      (reset_request_o || irq_request_o))
    else $error("error event without request");
  window_counting_a:
    assert property (refresh_window_o |-> counting_o)
    else $error("window open while stopped");
  underflow_single_a:
    assert property (underflow_event_o |=> !underflow_event_o)
    else $error("underflow pulse too long");
  lowpower_hold_a:
    assert property ((lowpower_state_i && stop_sel) [*6] |->
      $stable(count_value_o))
    else $error("count moved in low power");
  count_step_a:
    assert property ((counting_o && $past(counting_o) &&
      count_value_o != $past(count_value_o)) |->
      (count_value_o == $past(count_value_o) - 14'h0001 ||
       count_value_o[6:0] == 7'h7F))
    else $error("count jumped");
  start_value_a:
    assert property ($rose(counting_o) |-> count_value_o[6:0] == 7'h7F)
    else $error("bad start value");
endmodule // wdt_config_properties

bind independent_watchdog_config wdt_config_properties chk (.*);

/* File: testbench.sv */
// self-checking bench for the watchdog configuration block
// assumes the first timeout table and ref_clk_i at 250 MHz
`timescale 1ns/1ps
module testbench;
  reg ref_clk_i = 0, reset_n_i = 0, auto_start_mode_i = 0;
  reg [3:0] autostart_divider_select_i = 4'h0, divider_select_i = 4'h0;
  reg [1:0] autostart_timeout_select_i = 2'h1, timeout_select_i = 2'h0;
  reg [1:0] autostart_window_start_select_i = 2'h0;
  reg [1:0] autostart_window_end_select_i = 2'h3;
  reg [1:0] window_start_select_i = 2'h0, window_end_select_i = 2'h0;
  reg autostart_reset_or_irq_select_i = 1, reset_or_irq_select_i = 0;
  reg autostart_lowpower_count_stop_i = 1, lowpower_count_stop_i = 0;
  reg refresh_write_i = 0, lowpower_state_i = 0;
  reg [7:0] refresh_data_i = 8'h00;
  wire reset_request_o, irq_request_o, underflow_event_o;
  wire refresh_error_event_o, counting_o, refresh_window_o;
  wire [13:0] count_value_o;
  integer fails = 0, tests_run = 0, n, k;
  reg [13:0] c;
  reg [13:0] start_v [0:3];
  reg [13:0] start_w [0:3];
  wire [13:0] count_v2;
  reg [3:0] div_code [0:5];
  integer ratio [0:5];
  independent_watchdog_config #(.SECOND_VARIANT(0)) dut (.*);
  // second timeout table, only its count is observed
  independent_watchdog_config #(.SECOND_VARIANT(1)) dut_v2 (
    .*,
    .reset_request_o       (),
    .irq_request_o         (),
    .underflow_event_o     (),
    .refresh_error_event_o (),
    .counting_o            (),
    .refresh_window_o      (),
    .count_value_o         (count_v2)
  );
  initial forever #2 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task tick(input integer m);
    begin
      repeat (m) @(posedge ref_clk_i);
      #1;
    end
  endtask
  task check(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task do_reset(input a);
    begin
      reset_n_i = 0;
      auto_start_mode_i = a;
      tick(8);
      reset_n_i = 1;
      tick(2);
    end
  endtask
  task refresh;
    begin
      refresh_write_i = 1;
      refresh_data_i = 8'h00;
      tick(1);
      refresh_data_i = 8'hFF;
      tick(1);
      refresh_write_i = 0;
    end
  endtask
  task gap(output integer m);
    begin
      c = count_value_o;
      m = 0;
      while (count_value_o === c && m < 300) begin
        tick(1);
        m = m + 1;
      end
    end
  endtask
  task wait_win(input v);
    begin
      n = 0;
      while (refresh_window_o !== v && n < 1100) begin
        tick(1);
        n = n + 1;
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_table;
    begin
      do_reset(0);
      for (k = 0; k < 4; k = k + 1) begin
        timeout_select_i = k[1:0];
        refresh;
        tick(1);
        check(count_value_o, start_v[k]);
        check(count_v2, start_w[k]);
      end
      $display("table done");
    end
  endtask
  task t_odd;
    begin
      do_reset(0);
      refresh_write_i = 1;
      refresh_data_i = 8'h00;
      tick(1);
      refresh_data_i = 8'h55;
      tick(1);
      refresh_data_i = 8'hFF;
      tick(1);
      refresh_write_i = 0;
      tick(3);
      check(counting_o, 0);
      $display("odd write done");
    end
  endtask
  task t_divider;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        divider_select_i = div_code[k];
        refresh;
        tick(1);
        gap(n);
        gap(n);
        check(n, ratio[k]);
      end
      $display("divider done");
    end
  endtask
  task t_underflow;
    begin
      do_reset(0);
      timeout_select_i = 2'h0;
      divider_select_i = 4'h0;
      refresh;
      n = 0;
      while (underflow_event_o !== 1'b1 && n < 2000) begin
        tick(1);
        n = n + 1;
      end
      check(n >= 1024 && n <= 1026, 1);
      check({reset_request_o, irq_request_o}, 2'h2);
      tick(3);
      check(counting_o, 0);
      $display("underflow done");
    end
  endtask
  task t_start;
    begin
      reset_or_irq_select_i = 1;
      window_start_select_i = 2'h3;
      window_end_select_i = 2'h3;
      refresh;
      tick(4);
      refresh;
      check(refresh_error_event_o, 1);
      check({irq_request_o, reset_request_o}, 2'h2);
      tick(1);
      refresh;
      wait_win(1);
      check(refresh_window_o, 1);
      check(count_value_o, 14'h00FF);
      $display("window start done");
    end
  endtask
  task t_end;
    begin
      window_start_select_i = 2'h0;
      window_end_select_i = 2'h2;
      refresh;
      tick(3);
      check(refresh_window_o, 1);
      wait_win(0);
      check(refresh_window_o, 0);
      check(count_value_o, 14'h00FF);
      $display("window end done");
    end
  endtask
  task t_auto;
    begin
      do_reset(1);
      check({counting_o, count_value_o[13:8]}, 7'h4F);
      lowpower_state_i = 1;
      tick(8);
      c = count_value_o;
      tick(20);
      check(count_value_o, c);
      lowpower_state_i = 0;
      tick(6);
      check(count_value_o !== c, 1);
      $display("auto start done");
    end
  endtask
  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task close_out;
    begin
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    start_v[0] = 14'h03FF;
    start_v[1] = 14'h0FFF;
    start_v[2] = 14'h1FFF;
    start_v[3] = 14'h3FFF;
    start_w[0] = 14'h007F;
    start_w[1] = 14'h01FF;
    start_w[2] = 14'h03FF;
    start_w[3] = 14'h07FF;
    div_code[0] = 4'h0; div_code[1] = 4'h2; div_code[2] = 4'h3;
    div_code[3] = 4'h4; div_code[4] = 4'hF; div_code[5] = 4'h5;
    ratio[0] = 1; ratio[1] = 16; ratio[2] = 32;
    ratio[3] = 64; ratio[4] = 128; ratio[5] = 256;
    t_table;
    t_odd;
    t_divider;
    t_underflow;
    t_start;
    t_end;
    t_auto;
    close_out;
  end
  initial begin
    #80000;
    fails = fails + 1;
    close_out;
  end
endmodule // testbench
